// ---- rtl/buck_seq_pkg.sv ----
/*
  shared constants, types and register map for the buck channel fault sequencer.
  assumes a single pclk domain and a 32-bit apb register bus.
*/
package buck_seq_pkg;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] STATUS_OFS     = 8'h04;
  localparam logic [7:0] INT_STAT_OFS   = 8'h08;
  localparam logic [7:0] INT_MASK_OFS   = 8'h0C;
  localparam logic [7:0] HICCUP_CNT_OFS = 8'h10;

  // control register fields and reset value
  localparam int         CTRL_ENABLE_BIT = 0;
  localparam logic [0:0] CTRL_RESET      = 1'h1;

  // interrupt event bit positions
  localparam int EVT_W        = 5;
  localparam int EVT_HICCUP   = 0;
  localparam int EVT_OVP      = 1;
  localparam int EVT_STANDBY  = 2;
  localparam int EVT_OTP      = 3;
  localparam int EVT_POWER_OK = 4;

  // sequencing counts: pwm cycles, soft-start cycles for hiccup, pclk cycles per pwm cycle for the divider
  localparam int OC_LIMIT       = 7;
  localparam int HICCUP_CYCLES  = 7;
  localparam int RECONNECT_WAIT = 64;
  localparam int PWM_DIV_DEF    = 250;

  // states, gray coded along off -> wait -> run -> hiccup -> off
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_WAIT    = 3'b001,
    ST_RUN     = 3'b011,
    ST_HICCUP  = 3'b010,
    ST_OVP     = 3'b110,
    ST_STANDBY = 3'b111,
    ST_OTP     = 3'b101
  } seq_state_e;

  // comparator results from the analog front end
  typedef struct packed {
    logic en_above_1v;       // input_enable_sense over 1 v
    logic en_above_2v;       // input_enable_sense at 2 v
    logic por_ok;            // regulator_output and internal_bias_rail in regulation
    logic track_ge_fb;       // soft_start_track at or above feedback_sense
    logic track_above_1v4;   // soft_start_track over 1.4 v
    logic track_low;         // soft-start capacitor discharged
    logic track_slave;       // soft_start_track pulled up to 5 v
    logic overcurrent;
    logic fb_under_uv;       // feedback_sense below 0.588 v
    logic fb_over_ov;        // feedback_sense above 810 mv
    logic over_temp;         // die above 155 c
    logic temp_cooled;       // die has dropped by 30 c
    logic clock_slave;       // channel follows phase_clock_io
    logic clock_missing_fault;
    logic phase_select_open; // phase_select_pin above 4 v
  } cmp_s;

endpackage : buck_seq_pkg

// ---- rtl/buck_fault_sequencer.sv ----
/*
  start-up and protection sequencer for one buck channel, with an apb register slave.
  assumes comparator results arrive as levels, and gate drivers act on the
  permission outputs; pwm timing is an enable pulse divided from pclk.
*/
// How it works
// (R1) charge at 6 ua, 12 ua after first pulse
// (R2) hold switching until track reaches feedback
// (R3) power good low until track exceeds 1.4 v
// (R4) power good released when good, pulled low otherwise
// (R5) slave track at 5 v tristates error amp
// (R6) regulator on at 1 v, switching at 2 v
// (R7) both switches off until por confirms rails
// (R8) seven overcurrent cycles force hiccup, switches off
// (R9) hiccup: seven soft-start cycles then restart
// (R10) undervoltage enters the same hiccup
// (R11) overvoltage: lower on until undervoltage, then hiccup
// (R12) overvoltage guard active whenever enabled
// (R13) no start when output already overvoltage
// (R14) lost phase clock on slave gives standby
// (R15) open phase select: standby, 64 cycles resume
// (R16) over temperature kills switches and regulator
// (R17) track held low masks undervoltage and hiccup
// (R18) overcurrent count consecutive; comparators synchronised
`timescale 1ns/1ps
module buck_fault_sequencer
  import buck_seq_pkg::*;
#(
  parameter int PWM_DIV = PWM_DIV_DEF
) (
  // clock and reset
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  // apb slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // analog comparators
  input  wire  cmp_s        cmp_in,
  // soft-start current source
  output logic              ss_charge_en,
  output logic              ss_current_high,
  output logic              ss_discharge,
  // power stage
  output logic              switch_enable,
  output logic              gate_upper_en,
  output logic              gate_lower_en,
  output logic              cycle_terminate,
  output logic              error_amp_hiz,
  output logic              regulator_enable,
  // status
  output logic              power_ok_out,
  output logic              power_ok_oe,
  output logic              standby,
  output logic              hiccup_active,
  output logic              irq
);

  generate
    if (PWM_DIV < 2) begin : g_bad_div
      $error("PWM_DIV must be at least 2");
    end
  endgenerate

  localparam int DIV_W = $clog2(PWM_DIV);

  //////////////////////////////////////////////////////////////////////////////
  // comparator synchroniser and pwm tick

  cmp_s              cmp_meta;
  cmp_s              cmp;
  logic [DIV_W-1:0]  div_cnt;
  logic              pwm_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta <= '0;
      cmp      <= '0;
    end else begin
      cmp_meta <= cmp_in;  // [R18]
      cmp      <= cmp_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt  <= '0;
      pwm_tick <= 1'b0;
    end else begin
      pwm_tick <= (div_cnt == DIV_W'(PWM_DIV - 1));
      div_cnt  <= (div_cnt == DIV_W'(PWM_DIV - 1)) ? '0 : div_cnt + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic                 sw_enable;
  logic [EVT_W-1:0]     int_stat;
  logic [EVT_W-1:0]     int_mask;
  logic [EVT_W-1:0]     evt;
  logic [15:0]          hiccup_total;
  seq_state_e           state;

  wire setup_phase = psel && !penable;
  wire wr_access   = psel && penable && pwrite && pready;
  wire hit_ctrl    = (paddr == CTRL_OFS);
  wire hit_status  = (paddr == STATUS_OFS);
  wire hit_istat   = (paddr == INT_STAT_OFS);
  wire hit_imask   = (paddr == INT_MASK_OFS);
  wire hit_hcnt    = (paddr == HICCUP_CNT_OFS);
  wire mapped      = hit_ctrl || hit_status || hit_istat || hit_imask || hit_hcnt;
  wire [EVT_W-1:0] w1c = (wr_access && hit_istat) ? pwdata[EVT_W-1:0] : '0;
  wire [EVT_W-1:0] next_int_stat = (int_stat & ~w1c) | evt;
  wire [EVT_W-1:0] next_int_mask = (wr_access && hit_imask) ? pwdata[EVT_W-1:0] : int_mask;

  wire [31:0] status_word = {22'h00_0000, power_ok_oe, standby, hiccup_active,
                             gate_lower_en, gate_upper_en, switch_enable, 1'b0, state};
  wire [31:0] rd_mux = hit_ctrl   ? {31'h0000_0000, sw_enable} :
                       hit_status ? status_word :
                       hit_istat  ? {27'h000_0000, int_stat} :
                       hit_imask  ? {27'h000_0000, int_mask} :
                       hit_hcnt   ? {16'h0000, hiccup_total} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !mapped;
      prdata  <= (setup_phase && !pwrite) ? rd_mux : prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_enable <= CTRL_RESET[0];
      int_stat  <= '0;
      int_mask  <= '0;
      irq       <= 1'b0;
    end else begin
      if (wr_access && hit_ctrl) begin
        sw_enable <= pwdata[CTRL_ENABLE_BIT];
      end
      int_stat <= next_int_stat;  // set wins over clear
      int_mask <= next_int_mask;
      irq      <= |(next_int_stat & next_int_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer

  seq_state_e  next_state;
  logic [2:0]  oc_cnt;
  logic [2:0]  hic_cnt;
  logic        hic_discharge;
  logic [6:0]  reconnect_cnt;
  logic        first_pulse_done;

  wire enabled     = cmp.por_ok && cmp.en_above_2v && sw_enable;  // [R6] [R7]
  wire masked      = !cmp.track_above_1v4;                        // [R17]
  wire clk_lost    = cmp.clock_slave && cmp.clock_missing_fault;  // [R14]
  wire phase_ready = (reconnect_cnt == 7'(RECONNECT_WAIT));       // [R15]
  wire want_standby = clk_lost || cmp.phase_select_open || !phase_ready;
  wire oc_trip     = pwm_tick && cmp.overcurrent && !masked
                     && (oc_cnt == 3'(OC_LIMIT - 1));             // [R8]
  wire uv_trip     = cmp.fb_under_uv && !masked;                  // [R10] [R17]
  wire hic_done    = hic_discharge && cmp.track_low
                     && (hic_cnt == 3'(HICCUP_CYCLES - 1));       // [R9]

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (enabled && !cmp.over_temp) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // [R2] [R13] no pulse while track lags feedback or output is overvoltage
        if (pwm_tick && cmp.track_ge_fb && !cmp.fb_over_ov && !want_standby) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (oc_trip || uv_trip) begin
          next_state = ST_HICCUP;  // [R8] [R10]
        end
      end
      ST_HICCUP: begin
        if (hic_done) begin
          next_state = ST_WAIT;  // [R9]
        end
      end
      ST_OVP: begin
        if (cmp.fb_under_uv) begin
          next_state = ST_HICCUP;  // [R11]
        end
      end
      ST_STANDBY: begin
        if (!want_standby) begin
          next_state = ST_WAIT;  // [R14] [R15]
        end
      end
      ST_OTP: begin
        if (cmp.temp_cooled && !cmp.over_temp) begin
          next_state = ST_OFF;  // [R16]
        end
      end
      default: next_state = ST_OFF;
    endcase
    // protective overrides, highest priority last
    if ((state == ST_WAIT || state == ST_RUN) && want_standby) begin
      next_state = ST_STANDBY;
    end
    if (state != ST_OFF && state != ST_OTP && cmp.fb_over_ov && enabled) begin
      next_state = ST_OVP;  // [R11] [R12]
    end
    if (state != ST_OFF && state != ST_OTP && !enabled) begin
      next_state = ST_OFF;  // [R7]
    end
    if (cmp.over_temp && cmp.en_above_1v) begin
      next_state = ST_OTP;  // [R16]
    end
  end

  wire next_run    = (next_state == ST_RUN);
  wire next_charge = (next_state == ST_WAIT) || next_run
                     || (next_state == ST_HICCUP && !hic_discharge);
  wire next_dis    = (next_state == ST_OFF)
                     || (next_state == ST_HICCUP && hic_discharge);
  wire next_pok    = next_run && cmp.track_above_1v4 && !cmp.fb_under_uv
                     && !cmp.overcurrent && !cmp.over_temp && !cmp.fb_over_ov;

  assign evt[EVT_HICCUP]   = (next_state == ST_HICCUP) && (state != ST_HICCUP);
  assign evt[EVT_OVP]      = (next_state == ST_OVP) && (state != ST_OVP);
  assign evt[EVT_STANDBY]  = (next_state == ST_STANDBY) && (state != ST_STANDBY);
  assign evt[EVT_OTP]      = (next_state == ST_OTP) && (state != ST_OTP);
  assign evt[EVT_POWER_OK] = next_pok && power_ok_oe;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // consecutive overcurrent cycles, cleared by any clean cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_cnt <= '0;
    end else if (state != ST_RUN || oc_trip) begin
      oc_cnt <= '0;
    end else if (pwm_tick) begin
      oc_cnt <= cmp.overcurrent ? oc_cnt + 1'b1 : 3'd0;  // [R18]
    end
  end

  // hiccup charge and discharge of the soft-start capacitor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hic_cnt       <= '0;
      hic_discharge <= 1'b0;
      hiccup_total  <= '0;
    end else if (state != ST_HICCUP) begin
      hic_cnt       <= '0;
      hic_discharge <= 1'b0;
      if (next_state == ST_HICCUP) begin
        hiccup_total <= hiccup_total + 1'b1;
      end
    end else if (!hic_discharge && cmp.track_above_1v4) begin
      hic_discharge <= 1'b1;
    end else if (hic_discharge && cmp.track_low) begin
      hic_discharge <= 1'b0;
      hic_cnt       <= hic_cnt + 1'b1;  // [R9]
    end
  end

  // saturates at the resume count; any open reading restarts the wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reconnect_cnt <= 7'(RECONNECT_WAIT);
    end else if (cmp.phase_select_open) begin
      reconnect_cnt <= '0;
    end else if (pwm_tick && !phase_ready) begin
      reconnect_cnt <= reconnect_cnt + 1'b1;  // [R15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pulse_done <= 1'b0;
    end else if (!next_run) begin
      first_pulse_done <= 1'b0;
    end else if (pwm_tick) begin
      first_pulse_done <= 1'b1;  // [R1]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs; gates follow next_state so they line up with state

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_charge_en     <= 1'b0;
      ss_current_high  <= 1'b0;
      ss_discharge     <= 1'b1;
      switch_enable    <= 1'b0;
      gate_upper_en    <= 1'b0;
      gate_lower_en    <= 1'b0;
      cycle_terminate  <= 1'b0;
      error_amp_hiz    <= 1'b0;
      regulator_enable <= 1'b0;
      power_ok_out     <= 1'b0;
      power_ok_oe      <= 1'b1;
      standby          <= 1'b0;
      hiccup_active    <= 1'b0;
    end else begin
      ss_charge_en     <= next_charge;
      ss_current_high  <= next_run && first_pulse_done;                     // [R1]
      ss_discharge     <= next_dis;
      switch_enable    <= next_run;                                         // [R2]
      gate_upper_en    <= next_run;                                         // [R7] [R8]
      gate_lower_en    <= next_run || (next_state == ST_OVP);               // [R11]
      cycle_terminate  <= next_run && cmp.overcurrent;                      // [R17]
      error_amp_hiz    <= cmp.track_slave;                                  // [R5]
      regulator_enable <= cmp.en_above_1v && (next_state != ST_OTP);        // [R6] [R16]
      power_ok_out     <= 1'b0;
      power_ok_oe      <= !next_pok;                                        // [R3] [R4]
      standby          <= (next_state == ST_STANDBY);                       // [R14]
      hiccup_active    <= (next_state == ST_HICCUP);                        // [R9]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ss_high;
    $rose(ss_current_high) |-> state == ST_RUN && $past(switch_enable);
  endproperty
  a_ss_high: assert property (p_ss_high) else $error("12 ua before first pulse"); // [R1]

  property p_start_track;
    $rose(switch_enable) |-> $past(cmp.track_ge_fb) && !$past(cmp.fb_over_ov);
  endproperty
  a_start_track: assert property (p_start_track) else $error("switching too early"); // [R2] [R13]

  property p_pok_low;
    !cmp.track_above_1v4 |=> power_ok_oe;
  endproperty
  a_pok_low: assert property (p_pok_low) else $error("power good released early"); // [R3] [R4]

  property p_reg_off;
    !cmp.en_above_1v |=> !regulator_enable;
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("regulator on below 1 v"); // [R6]

  property p_por_off;
    !cmp.por_ok |=> !gate_upper_en && !gate_lower_en;
  endproperty
  a_por_off: assert property (p_por_off) else $error("gate on without por"); // [R7]

  property p_oc_trip;
    state == ST_RUN && oc_trip && enabled && !cmp.fb_over_ov && !cmp.over_temp
      && !want_standby |=> state == ST_HICCUP && !gate_upper_en && !gate_lower_en;
  endproperty
  a_oc_trip: assert property (p_oc_trip) else $error("no hiccup after 7 oc cycles"); // [R8]

  property p_hiccup_off;
    state == ST_HICCUP |-> !gate_upper_en && !gate_lower_en && !switch_enable;
  endproperty
  a_hiccup_off: assert property (p_hiccup_off) else $error("switching in hiccup"); // [R9]

  property p_ovp_gates;
    state == ST_OVP |-> !gate_upper_en && gate_lower_en;
  endproperty
  a_ovp_gates: assert property (p_ovp_gates) else $error("wrong gates in ovp"); // [R11]

  property p_ovp_entry;
    enabled && cmp.fb_over_ov && !cmp.over_temp && state != ST_OFF && state != ST_OTP
      |=> state == ST_OVP;
  endproperty
  a_ovp_entry: assert property (p_ovp_entry) else $error("overvoltage missed"); // [R12]

  property p_mask;
    state == ST_RUN && masked |=> state != ST_HICCUP;
  endproperty
  a_mask: assert property (p_mask) else $error("hiccup while track held low"); // [R17]

  property p_otp;
    cmp.over_temp && cmp.en_above_1v |=> !regulator_enable && !gate_upper_en;
  endproperty
  a_otp: assert property (p_otp) else $error("over temperature not obeyed"); // [R16]

  property p_irq;
    irq == |(int_stat & int_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq disagrees with status");

endmodule : buck_fault_sequencer

// ---- dv/buck_analog_model.sv ----
/*
  behavioural soft-start capacitor and comparator front end for the sequencer.
  assumes the bench sets feedback level, track clamp and the other comparator levels.
*/
`timescale 1ns/1ps
module buck_analog_model
  import buck_seq_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // soft-start source
  input  wire logic        ss_charge_en,
  input  wire logic        ss_current_high,
  input  wire logic        ss_discharge,
  // bench-set conditions
  input  wire cmp_s        ext,
  input  wire logic [11:0] fb_mv,
  input  wire logic [11:0] trk_max,
  // comparator results
  output cmp_s             cmp,
  output logic [11:0]      trk_mv
);
  logic [11:0] next_trk;
  logic [11:0] step;

  ////////////////////////////////////////////////////////////////////////////////
  // one count per mv; 6 or 12 per cycle stands in for the two charge currents
  assign step = ss_current_high ? 12'h00c : 12'h006;

  always_comb begin
    next_trk = trk_mv;
    if (ss_discharge) begin
      next_trk = (trk_mv > 12'h032) ? trk_mv - 12'h032 : 12'h000;
    end else if (ss_charge_en) begin
      next_trk = trk_mv + step;
      // internal clamp at 2.4 v, or lower when held down from outside
      if (next_trk > trk_max) next_trk = trk_max;
      if (next_trk > 12'h960) next_trk = 12'h960;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) trk_mv <= 12'h000;
    else          trk_mv <= next_trk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cmp                 = ext; // track pulled to 5 v comes from outside
    cmp.track_ge_fb     = (trk_mv >= fb_mv);
    cmp.track_above_1v4 = (trk_mv > 12'h578);
    cmp.track_low       = (trk_mv < 12'h032);
    cmp.fb_under_uv     = (fb_mv < 12'h24c);
    cmp.fb_over_ov      = (fb_mv > 12'h32a);
  end
endmodule : buck_analog_model

// ---- dv/tb_top.sv ----
/*
  self-checking bench for the buck fault sequencer: apb tasks and fault scenarios.
  assumes the analog model stands at the comparator and soft-start ports.
*/
`timescale 1ns/1ps
module tb_top
  import buck_seq_pkg::*;
;
  localparam int PDIV = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic ss_charge_en, ss_current_high, ss_discharge, switch_enable, gate_upper_en;
  logic gate_lower_en, cycle_terminate, error_amp_hiz, regulator_enable;
  logic power_ok_out, power_ok_oe, standby, hiccup_active, err, dis_q, sw_q;
  cmp_s ext, cmp;
  logic [11:0] fb_mv, trk_max, trk_mv, trk_at_run;
  int error_cnt, comparisons, dis_cnt, base, n;

  buck_fault_sequencer #(.PWM_DIV(PDIV)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_in(cmp), .ss_charge_en(ss_charge_en),
    .ss_current_high(ss_current_high), .ss_discharge(ss_discharge),
    .switch_enable(switch_enable), .gate_upper_en(gate_upper_en),
    .gate_lower_en(gate_lower_en), .cycle_terminate(cycle_terminate),
    .error_amp_hiz(error_amp_hiz), .regulator_enable(regulator_enable),
    .power_ok_out(power_ok_out), .power_ok_oe(power_ok_oe), .standby(standby),
    .hiccup_active(hiccup_active), .irq(irq));

  buck_analog_model model (.pclk(pclk), .presetn(presetn), .ss_charge_en(ss_charge_en),
    .ss_current_high(ss_current_high), .ss_discharge(ss_discharge), .ext(ext),
    .fb_mv(fb_mv), .trk_max(trk_max), .cmp(cmp), .trk_mv(trk_mv));

  always #2 pclk = ~pclk;

  // discharge phases inside hiccup, and the track level each time switching starts
  always @(posedge pclk) begin
    dis_q <= ss_discharge;
    sw_q  <= switch_enable;
    if (hiccup_active && ss_discharge && !dis_q) dis_cnt <= dis_cnt + 1;
    if (switch_enable && !sw_q) trk_at_run <= trk_mv;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer

  // polls the state code; a state never reached shows as a mismatch
  task automatic wait_st(input logic [2:0] s);
    for (int i = 0; i < 2500; i++) begin
      xfer(1'b0, STATUS_OFS, 32'h0000_0000);
      if (d[2:0] === s) break;
    end
    check(d[2:0], s);
  endtask : wait_st

  task automatic summarize;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial begin
    #200000;
    error_cnt++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    ext = '0; fb_mv = 12'h28a; trk_max = 12'h960; dis_cnt = 0;
    repeat (12) @(posedge pclk);
    check(power_ok_oe, 1'b1);
    presetn <= 1'b1;
    xfer(1'b0, CTRL_OFS, 32'h0000_0000);
    check(d, 32'h0000_0001);
    xfer(1'b0, INT_MASK_OFS, 32'h0000_0000);
    check(d, 32'h0000_0000);
    xfer(1'b1, 8'h20, 32'h0000_ffff);
    check(err, 1'b1);
    ext.en_above_1v <= 1'b1;
    repeat (8) @(posedge pclk);
    check({regulator_enable, switch_enable}, 2'b10);
    ext.en_above_2v <= 1'b1;
    wait_st(ST_OFF);
    check({gate_upper_en, gate_lower_en}, 2'b00);
    xfer(1'b1, INT_MASK_OFS, 32'h0000_0001 << EVT_HICCUP);
    ext.por_ok <= 1'b1;
    wait_st(ST_WAIT);
    check(ss_current_high, 1'b0);
    check({ss_charge_en, ss_discharge}, 2'b10);
    wait_st(ST_RUN);
    check(trk_at_run >= fb_mv, 1'b1);
    check(power_ok_oe, 1'b1);
    repeat (200) @(posedge pclk);
    check(ss_current_high, 1'b1);
    check({power_ok_oe, power_ok_out}, 2'b00);
    ext.track_slave <= 1'b1;
    repeat (5) @(posedge pclk);
    check(error_amp_hiz, 1'b1);
    ext.track_slave <= 1'b0;
    // overcurrent: no hiccup after five switching cycles, then hiccup
    base = dis_cnt;
    ext.overcurrent <= 1'b1;
    repeat (5 * PDIV) @(posedge pclk);
    check(hiccup_active, 1'b0);
    wait_st(ST_HICCUP);
    check({gate_upper_en, gate_lower_en}, 2'b00);
    xfer(1'b0, HICCUP_CNT_OFS, 32'h0000_0000);
    check(d, 32'h0000_0001);
    check(irq, 1'b1);
    xfer(1'b1, INT_STAT_OFS, 32'h0000_0001 << EVT_HICCUP);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0);
    ext.overcurrent <= 1'b0;
    wait_st(ST_RUN);
    check(dis_cnt - base, HICCUP_CYCLES);
    repeat (200) @(posedge pclk);
    fb_mv <= 12'h1f4;
    wait_st(ST_HICCUP);
    fb_mv <= 12'h28a;
    wait_st(ST_RUN);
    repeat (200) @(posedge pclk);
    xfer(1'b1, INT_MASK_OFS, 32'h0000_0000);
    fb_mv <= 12'h384;
    wait_st(ST_OVP);
    check({gate_upper_en, gate_lower_en}, 2'b01);
    xfer(1'b0, INT_STAT_OFS, 32'h0000_0000);
    check(d[EVT_OVP], 1'b1);
    check(irq, 1'b0);
    fb_mv <= 12'h1f4;
    wait_st(ST_HICCUP);
    // overvoltage already present before any switching
    xfer(1'b1, CTRL_OFS, 32'h0000_0000);
    wait_st(ST_OFF);
    fb_mv <= 12'h384;
    xfer(1'b1, CTRL_OFS, 32'h0000_0001);
    wait_st(ST_OVP);
    check({switch_enable, gate_lower_en}, 2'b01);
    fb_mv <= 12'h1f4;
    wait_st(ST_HICCUP);
    fb_mv <= 12'h28a;
    wait_st(ST_RUN);
    ext.phase_select_open <= 1'b1;
    wait_st(ST_STANDBY);
    check({gate_upper_en, gate_lower_en, regulator_enable}, 3'b001);
    ext.phase_select_open <= 1'b0;
    for (n = 0; n < 1000 && standby !== 1'b0; n++) @(posedge pclk);
    check(n >= 63 * PDIV && n <= 66 * PDIV + 8, 1'b1);
    ext.clock_slave <= 1'b1;
    ext.clock_missing_fault <= 1'b1;
    wait_st(ST_STANDBY);
    check({gate_upper_en, gate_lower_en, regulator_enable}, 3'b001);
    ext.clock_missing_fault <= 1'b0;
    wait_st(ST_RUN);
    ext.over_temp <= 1'b1;
    wait_st(ST_OTP);
    check({gate_upper_en, gate_lower_en, regulator_enable}, 3'b000);
    ext.over_temp <= 1'b0;
    ext.temp_cooled <= 1'b1;
    wait_st(ST_RUN);
    ext.temp_cooled <= 1'b0;
    // track held below 1.4 v from outside
    trk_max <= 12'h3e8;
    xfer(1'b1, CTRL_OFS, 32'h0000_0000);
    wait_st(ST_OFF);
    xfer(1'b1, CTRL_OFS, 32'h0000_0001);
    wait_st(ST_RUN);
    fb_mv <= 12'h258;
    ext.overcurrent <= 1'b1;
    repeat (12 * PDIV) @(posedge pclk);
    check({cycle_terminate, hiccup_active, power_ok_oe}, 3'b101);
    fb_mv <= 12'h1f4;
    repeat (12 * PDIV) @(posedge pclk);
    wait_st(ST_RUN);
    summarize();
  end
endmodule : tb_top
